// *** logic/vrf_map.svh ***
// constants for the regulator supervisor: offsets, fields, resets, timing
`ifndef VRF_MAP_SVH
`define VRF_MAP_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define VRF_CTRL_OFS        8'h00
`define VRF_STATUS_OFS      8'h04

// ****************************************************************
// control register fields
// ****************************************************************
`define VRF_CTRL_VID_LSB    0
`define VRF_CTRL_VID_MSB    7
`define VRF_CTRL_SHED_LSB   8
`define VRF_CTRL_SHED_MSB   9
`define VRF_CTRL_VID_RST    8'h00
`define VRF_CTRL_SHED_RST   2'h0

// ****************************************************************
// status register fields
// ****************************************************************
`define VRF_STAT_DAC_LSB    0
`define VRF_STAT_CFG_LSB    8
`define VRF_STAT_STATE_LSB  16
`define VRF_STAT_OVP_BIT    20
`define VRF_STAT_OCP_BIT    21

// ****************************************************************
// timing
// ****************************************************************
`define VRF_CLK_MHZ         25
`define VRF_OCP_DELAY_NS    50000
`define VRF_OCP_CYCLES      ((`VRF_OCP_DELAY_NS * `VRF_CLK_MHZ + 999) / 1000)
`define VRF_SS_STEP_CYCLES  4

`endif

// *** logic/vrf_pkg.sv ***
// types shared by the regulator supervisor
package vrf_pkg;

  // ****************************************************************
  // pwm output levels and sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {PWM_LOW, PWM_HIGH, PWM_MID} vrf_pwm_t;

  typedef enum logic [3:0] {
    ST_OFF, ST_DETECT, ST_SOFTSTART, ST_RUN, ST_OVP_RAMP, ST_OVP_HOLD, ST_OCP_LATCH
  } vrf_state_t;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic single_phase_strap_pos;
    logic single_phase_strap_neg;
    logic second_phase_pwm_high;
    logic second_phase_pwm_float;
    logic aux_boot_strap;
  } vrf_straps_t;

  typedef struct packed {
    logic ramp_supply_uv;
    logic current_limit_sense_over_100;
    logic current_limit_sense_over_150;
    logic out_uv;
    logic ovp_dac;
    logic ovp_current_sense_reference;
  } vrf_sense_t;

  typedef struct packed {
    logic [1:0] core_phases;
    logic       aux_on;
    logic       addr_any_parity;
    logic       single;
  } vrf_cfg_t;

endpackage : vrf_pkg

// *** logic/vrf_supervisor.sv ***
// fault supervisor and phase configuration of a multiphase regulator
`timescale 1ns/1ns
`include "vrf_map.svh"

module vrf_supervisor #(
  parameter int SS_STEP_CYCLES = `VRF_SS_STEP_CYCLES,
  parameter int OCP_CYCLES     = `VRF_OCP_CYCLES
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // ahb-lite slave
  input  wire logic                 i_hsel,
  input  wire logic [31:0]          i_haddr,
  input  wire logic [1:0]           i_htrans,
  input  wire logic                 i_hwrite,
  input  wire logic [2:0]           i_hsize,
  input  wire logic [31:0]          i_hwdata,
  input  wire logic                 i_hready,
  output logic      [31:0]          o_hrdata,
  output logic                      o_hreadyout,
  output logic                      o_hresp,
  // pins and comparators
  input  wire logic                 i_enable,
  input  wire logic                 i_driver_power_ok,
  input  wire logic                 i_dynamic_voltage_change,
  input  wire vrf_pkg::vrf_straps_t i_straps,
  input  wire vrf_pkg::vrf_sense_t  i_sense,
  input  wire logic [3:0]           i_pwm_demand,
  // outputs to drivers and board
  output vrf_pkg::vrf_pwm_t [3:0]   o_pwm,
  output logic                      o_driver_power_ok_oe,
  output logic                      o_core_regulation_good_oe,
  output logic [7:0]                o_dac,
  output logic [1:0]                o_current_limit_sense_scale,
  output vrf_pkg::vrf_cfg_t         o_cfg
);
  import vrf_pkg::*;

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  if (SS_STEP_CYCLES < 1 || SS_STEP_CYCLES > 255) begin : g_ss_chk
    $error("soft-start step out of range");
  end
  if (OCP_CYCLES < 2 || OCP_CYCLES > 2047) begin : g_ocp_chk
    $error("over-current delay out of range");
  end
  if (`VRF_STAT_OCP_BIT > 31 || `VRF_STAT_OVP_BIT < `VRF_STAT_STATE_LSB + 4) begin : g_flg_chk
    $error("status flags misplaced");
  end
  if (`VRF_CTRL_SHED_MSB > 31 || `VRF_CTRL_SHED_LSB <= `VRF_CTRL_VID_MSB) begin : g_ctrl_chk
    $error("control fields overlap or overflow");
  end
  if ((`VRF_CTRL_VID_MSB - `VRF_CTRL_VID_LSB) != 7) begin : g_vid_chk
    $error("vid field must match the eight-bit dac");
  end
  if (`VRF_STAT_CFG_LSB < `VRF_STAT_DAC_LSB + 8) begin : g_cfg_chk
    $error("status dac and cfg fields overlap");
  end
  if (`VRF_STAT_STATE_LSB < `VRF_STAT_CFG_LSB + 5) begin : g_st_chk
    $error("status cfg and state fields overlap");
  end
  if ($bits(vrf_state_t) != 4) begin : g_enum_chk
    $error("state enum must fit the four-bit status field");
  end
  if (`VRF_STATUS_OFS == `VRF_CTRL_OFS) begin : g_ofs_chk
    $error("register offsets collide");
  end

  // ****************************************************************
  // derived constants
  // ****************************************************************
  localparam logic [7:0]  SS_LAST  = 8'(SS_STEP_CYCLES - 1);
  localparam logic [10:0] OCP_LAST = 11'(OCP_CYCLES - 1);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    vrf_state_t        st;
    vrf_cfg_t          cfg;
    logic [7:0]        dac;
    logic [7:0]        step_cnt;
    logic [10:0]       ocp_cnt;
    logic [7:0]        vid_target;
    logic [1:0]        shed;
    vrf_pwm_t [3:0]    pwm;
    logic              drv_low;
    logic              rg_low;
    logic [1:0]        current_limit_sense_scale;
    logic              wr_pend;
    logic [7:0]        wr_addr;
    logic [31:0]       rdata;
    logic              hready;
    logic              hresp;
    logic              ocp_flag;
    logic              ovp_flag;
  } vrf_regs_t;

  vrf_regs_t q;
  vrf_regs_t next_q;

  logic [1:0] active;
  logic       tick;
  logic       fault_uv;
  logic       dac_ovp;
  logic       ocp_trip;

  always_comb begin
    next_q = q;
    // ****************************************************************
    // bus: registered read data, write lands in the data phase
    // ****************************************************************
    next_q.hready  = 1'b1;
    next_q.hresp   = 1'b0;
    next_q.wr_pend = 1'b0;
    if (q.wr_pend && q.wr_addr == `VRF_CTRL_OFS) begin
      next_q.vid_target = i_hwdata[`VRF_CTRL_VID_MSB:`VRF_CTRL_VID_LSB];
      next_q.shed       = i_hwdata[`VRF_CTRL_SHED_MSB:`VRF_CTRL_SHED_LSB];
    end

    // ****************************************************************
    // address phase: only whole-word transfers are taken, SEQ beats as well as NONSEQ
    // ****************************************************************
    // zero wait states, so a read right behind a control write sees the old value
    if (i_hsel && i_hready && i_htrans[1] && i_hsize == 3'h2) begin
      if (i_hwrite) begin
        next_q.wr_pend = 1'b1;
        next_q.wr_addr = i_haddr[7:0];
      end else begin
        next_q.rdata = 32'h0;
        if (i_haddr[7:0] == `VRF_CTRL_OFS) begin
          next_q.rdata[`VRF_CTRL_VID_MSB:`VRF_CTRL_VID_LSB]   = q.vid_target;
          next_q.rdata[`VRF_CTRL_SHED_MSB:`VRF_CTRL_SHED_LSB] = q.shed;
        end else if (i_haddr[7:0] == `VRF_STATUS_OFS) begin
          next_q.rdata[`VRF_STAT_DAC_LSB +: 8]   = q.dac;
          next_q.rdata[`VRF_STAT_CFG_LSB +: 5]   = q.cfg;
          next_q.rdata[`VRF_STAT_STATE_LSB +: 4] = q.st;
          next_q.rdata[`VRF_STAT_OVP_BIT]        = q.ovp_flag;
          next_q.rdata[`VRF_STAT_OCP_BIT]        = q.ocp_flag;
        end
      end
    end

    // ****************************************************************
    // active phase count
    // ****************************************************************
    // a shed request above the strapped count is ignored rather than trusted
    if (q.shed == 2'h0 || q.shed > q.cfg.core_phases) begin
      active = q.cfg.core_phases;
    end else begin
      active = q.shed;
    end
    // the total limit follows the phases that really conduct
    next_q.current_limit_sense_scale = active;

    // ****************************************************************
    // soft-start and ramp-down step timer
    // ****************************************************************
    // free running: the first step can come up to one period early, never late
    tick            = (q.step_cnt == SS_LAST);
    next_q.step_cnt = tick ? 8'h00 : q.step_cnt + 8'h01;

    // ****************************************************************
    // fault terms
    // ****************************************************************
    // only looked at in enabled states
    fault_uv = !i_driver_power_ok || i_sense.ramp_supply_uv;
    // the dac-relative check would trip on every start into a pre-charged rail
    dac_ovp  = i_sense.ovp_dac && q.st == ST_RUN && !i_dynamic_voltage_change;

    // ****************************************************************
    // over-current latch-off timer
    // ****************************************************************
    // saturates at the last count so a long fault cannot wrap and be forgotten
    if (i_sense.current_limit_sense_over_100) begin
      next_q.ocp_cnt = (q.ocp_cnt == OCP_LAST) ? q.ocp_cnt : q.ocp_cnt + 11'h001;
    end else begin
      next_q.ocp_cnt = 11'h000;
    end
    ocp_trip = i_sense.current_limit_sense_over_150 ||
               (i_sense.current_limit_sense_over_100 && q.ocp_cnt == OCP_LAST);

    // ****************************************************************
    // phase outputs
    // ****************************************************************
    // regulating phases follow the modulator, shed and unused phases idle at mid
    for (int i = 0; i < 4; i++) begin
      if (i < 3 ? (2'(i) < active) : q.cfg.aux_on) begin
        next_q.pwm[i] = i_pwm_demand[i] ? PWM_HIGH : PWM_LOW;
      end else begin
        next_q.pwm[i] = PWM_MID;
      end
    end
    next_q.drv_low = 1'b0;

    // ****************************************************************
    // regulation good
    // ****************************************************************
    // held low through soft-start so the flag never flickers during the ramp
    next_q.rg_low  = !(q.st == ST_RUN && !i_sense.out_uv);

    // ****************************************************************
    // sequencer
    // ****************************************************************
    case (q.st)
      // ****************************************************************
      // parked
      // ****************************************************************
      // flags clear here, so software sees a trip only until enable is cycled
      ST_OFF: begin
        next_q.pwm      = {4{PWM_MID}};
        next_q.drv_low  = 1'b1;
        next_q.dac      = 8'h00;
        next_q.ocp_flag = 1'b0;
        next_q.ovp_flag = 1'b0;
        if (i_enable) begin
          next_q.st = ST_DETECT;
        end
      end

      // ****************************************************************
      // strap detection
      // ****************************************************************
      // straps are read once per start; a later strap move needs an enable cycle
      ST_DETECT: begin
        next_q.pwm             = {4{PWM_MID}};
        next_q.cfg.single      = i_straps.single_phase_strap_pos &&
                                 !i_straps.single_phase_strap_neg;
        next_q.cfg.aux_on      = !i_straps.aux_boot_strap;
        next_q.cfg.addr_any_parity = i_straps.aux_boot_strap;
        if (next_q.cfg.single) begin
          // second_phase_pwm float or high with aux programmed gives 1+1
          next_q.cfg.core_phases = 2'h1;
        end else if (i_straps.second_phase_pwm_high) begin
          next_q.cfg.core_phases = 2'h2;
        end else begin
          next_q.cfg.core_phases = 2'h3;
        end
        next_q.dac = 8'h00;
        next_q.st  = ST_SOFTSTART;
      end

      // ****************************************************************
      // soft-start and regulation
      // ****************************************************************
      ST_SOFTSTART, ST_RUN: begin
        if (i_sense.ovp_current_sense_reference || dac_ovp) begin
          next_q.st       = ST_OVP_RAMP;
          next_q.ovp_flag = 1'b1;
          next_q.pwm      = {4{PWM_LOW}};
        end else if (ocp_trip) begin
          next_q.st       = ST_OCP_LATCH;
          next_q.ocp_flag = 1'b1;
        end else if (fault_uv) begin
          // the driver keeps power-ok low long enough for this restart
          next_q.st  = ST_SOFTSTART;
          next_q.dac = 8'h00;
          next_q.pwm = {4{PWM_MID}};
        end else if (q.st == ST_SOFTSTART) begin
          if (q.dac == q.vid_target) begin
            next_q.st = ST_RUN;
          end else if (tick) begin
            next_q.dac = (q.dac < q.vid_target) ? q.dac + 8'h01 : q.dac - 8'h01;
          end
        end else begin
          next_q.dac = q.vid_target;
        end
      end

      // ****************************************************************
      // over-voltage shutdown
      // ****************************************************************
      // a slow ramp keeps the output from swinging negative
      ST_OVP_RAMP: begin
        if (i_sense.ovp_dac || i_sense.ovp_current_sense_reference) begin
          next_q.pwm = {4{PWM_LOW}};
        end
        if (q.dac == 8'h00) begin
          next_q.st  = ST_OVP_HOLD;
          next_q.pwm = {4{PWM_LOW}};
        end else if (tick) begin
          next_q.dac = q.dac - 8'h01;
        end
      end
      ST_OVP_HOLD: begin
        next_q.pwm     = {4{PWM_LOW}};
        // drivers stay powered so the low-side switches keep clamping the output
        next_q.drv_low = 1'b0;
      end

      // ****************************************************************
      // over-current latch
      // ****************************************************************
      ST_OCP_LATCH: begin
        // latched until enable drops, which is checked below
        next_q.pwm     = {4{PWM_MID}};
        next_q.drv_low = 1'b1;
        next_q.dac     = 8'h00;
      end
      default: begin
        next_q.st = ST_OFF;
      end
    endcase

    // ****************************************************************
    // enable override
    // ****************************************************************
    // enable low overrides every state, the only way out of a latch
    if (!i_enable) begin
      next_q.st      = ST_OFF;
      next_q.pwm     = {4{PWM_MID}};
      next_q.drv_low = 1'b1;
      next_q.rg_low  = 1'b1;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q            <= '0;
      q.st         <= ST_OFF;
      q.pwm        <= {4{PWM_MID}};
      q.drv_low    <= 1'b1;
      q.rg_low     <= 1'b1;
      q.hready     <= 1'b1;
      q.vid_target <= `VRF_CTRL_VID_RST;
      q.shed       <= `VRF_CTRL_SHED_RST;
    end else begin
      q <= next_q;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_hrdata                  = q.rdata;
  assign o_hreadyout               = q.hready;
  assign o_hresp                   = q.hresp;
  assign o_pwm                     = q.pwm;
  assign o_driver_power_ok_oe      = q.drv_low;
  assign o_core_regulation_good_oe = q.rg_low;
  assign o_dac                     = q.dac;
  assign o_current_limit_sense_scale              = q.current_limit_sense_scale;
  assign o_cfg                     = q.cfg;

endmodule : vrf_supervisor

// *** tb/vrf_drv_model.sv ***
// gate driver model that shares the open-drain power-ok line
`timescale 1ns/1ns
module vrf_drv_model #(
  parameter int HOLD = 6
) (
  // clock and commands
  input  wire logic i_clk,
  input  wire logic i_brown,
  input  wire logic i_ctl_pull,
  // wired line
  output logic      o_line
);
  int cnt;
  // a short dip still holds the line low long enough for a restart
  always @(posedge i_clk) cnt <= i_brown ? HOLD : (cnt > 0 ? cnt - 1 : 0);
  // pull-up: a released line reads high
  assign o_line = !(i_ctl_pull || cnt > 0);
endmodule : vrf_drv_model

// *** tb/vrf_supervisor_asserts.sv ***
// concurrent checks on the supervisor ports
`timescale 1ns/1ns
module vrf_supervisor_asserts #(
  parameter int OCP_CYCLES = 10
) (
  // watched ports
  input wire logic                    i_clk,
  input wire logic                    i_rst,
  input wire logic                    i_enable,
  input wire logic                    i_driver_power_ok,
  input wire vrf_pkg::vrf_sense_t     i_sense,
  input wire vrf_pkg::vrf_pwm_t [3:0] o_pwm,
  input wire logic                    o_driver_power_ok_oe,
  input wire logic                    o_core_regulation_good_oe,
  input wire logic [7:0]              o_dac
);
  import vrf_pkg::*;
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  int  n;
  wire run = o_pwm[0] == PWM_HIGH;
  wire quiet = i_sense[1:0] == 2'h0;
  // counts only while enabled: the latch-off timer means nothing when off
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst) n <= 0;
    else n <= (i_enable && i_sense.current_limit_sense_over_100 && quiet) ? n + 1 : 0;
  sequence s_csr; (i_enable && i_sense.ovp_current_sense_reference)[*3]; endsequence
  sequence s_off; (!i_enable)[*3]; endsequence
  property p_off; s_off |-> o_pwm == {4{PWM_MID}} && o_dac == 8'h00; endproperty
  property p_uvr; i_enable && (!i_driver_power_ok || i_sense.ramp_supply_uv) && run
    && i_sense[4:0] == 5'h00 |-> ##[1:2] o_pwm[0] == PWM_MID; endproperty
  property p_fast; i_enable && i_sense.current_limit_sense_over_150 && quiet && run
    |-> ##[1:2] o_pwm[0] == PWM_MID && o_driver_power_ok_oe; endproperty
  property p_slow; n >= OCP_CYCLES + 3 |-> o_driver_power_ok_oe; endproperty
  property p_csr; i_enable && i_sense.ovp_current_sense_reference && run
    |-> ##[1:2] o_pwm[0] == PWM_LOW; endproperty
  property p_ramp; s_csr |=> o_dac <= $past(o_dac); endproperty
  property p_good; i_sense.out_uv |-> ##[1:2] o_core_regulation_good_oe; endproperty
  property p_enc; o_pwm[0] != 2'h3 && o_pwm[1] != 2'h3
    && o_pwm[2] != 2'h3 && o_pwm[3] != 2'h3; endproperty
  a_off: assert property (p_off) else $error("not parked while off");
  a_uvr: assert property (p_uvr) else $error("no restart on low supply");
  a_fast: assert property (p_fast) else $error("no fast trip");
  a_slow: assert property (p_slow) else $error("no timed trip");
  a_csr: assert property (p_csr) else $error("sense pin trip missed");
  a_ramp: assert property (p_ramp) else $error("dac rose after trip");
  a_good: assert property (p_good) else $error("good flag kept");
  a_enc: assert property (p_enc) else $error("bad pwm code");
endmodule : vrf_supervisor_asserts
bind vrf_supervisor vrf_supervisor_asserts #(.OCP_CYCLES(OCP_CYCLES)) u_vrf_chk (
  .i_clk, .i_rst, .i_enable, .i_driver_power_ok, .i_sense, .o_pwm,
  .o_driver_power_ok_oe, .o_core_regulation_good_oe, .o_dac);

// *** tb/vrf_supervisor_tb_top.sv ***
// self-checking bench for the regulator supervisor
`timescale 1ns/1ns
module vrf_supervisor_tb_top;
  import vrf_pkg::*;
  // ****************
  // harness
  // ****************
  localparam int OCP = 10;
  logic i_clk = 0, i_rst = 1, i_hsel = 0, i_hwrite = 0, i_enable = 0, brown = 0;
  logic i_dynamic_voltage_change = 0, o_hreadyout, o_hresp, i_driver_power_ok;
  logic o_driver_power_ok_oe, o_core_regulation_good_oe;
  logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata, q;
  logic [1:0] i_htrans = 0, o_current_limit_sense_scale;
  logic [2:0] i_hsize = 3'h2;
  logic [3:0] i_pwm_demand = 4'hf;
  logic [7:0] o_dac;
  vrf_straps_t i_straps = '0;
  vrf_sense_t i_sense = '0;
  vrf_pwm_t [3:0] o_pwm;
  vrf_cfg_t o_cfg;
  int n_errors = 0, total_checks = 0, cyc = 0;
  vrf_supervisor #(.OCP_CYCLES(OCP)) u_vrf_supervisor (
    .i_clk, .i_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata,
    .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp, .i_enable,
    .i_driver_power_ok, .i_dynamic_voltage_change, .i_straps, .i_sense, .i_pwm_demand,
    .o_pwm, .o_driver_power_ok_oe, .o_core_regulation_good_oe, .o_dac, .o_current_limit_sense_scale, .o_cfg);
  vrf_drv_model u_vrf_drv_model (.i_clk, .i_brown(brown), .i_ctl_pull(o_driver_power_ok_oe),
    .o_line(i_driver_power_ok));
  initial forever #20 i_clk = ~i_clk;
  task automatic wrap_up;
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      $display("BAD %0t timeout", $time);
      wrap_up;
    end
  end
  task automatic clks(input int n);
    repeat (n) @(posedge i_clk);
  endtask : clks
  // outputs are read just after an edge, so they show the settled pre-edge value
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : cmp
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_hsel <= 1'h1;
    i_htrans <= 2'h2;
    i_hwrite <= w;
    i_haddr <= {24'h0, a};
    do @(posedge i_clk); while (o_hreadyout !== 1'h1);
    i_hsel <= 1'h0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_clk); while (o_hreadyout !== 1'h1);
    q = o_hrdata;
  endtask : bus
  task automatic wait_st(input logic [3:0] s);
    q = '1;
    for (int i = 0; i < 100 && q[19:16] !== s; i++)
      bus(1'h0, 8'h04, 32'h0);
    cmp(q[19:16], s);
  endtask : wait_st
  function automatic logic [4:0] ecfg(input logic [4:0] s);
    logic sg;
    sg = s[4] & ~s[3];
    return {sg ? 2'h1 : (s[2] ? 2'h2 : 2'h3), ~s[0], s[0], sg};
  endfunction : ecfg
  task automatic go(input logic [4:0] st);
    logic [4:0] e;
    e = ecfg(st);
    @(posedge i_clk);
    i_enable <= 1'h0;
    i_straps <= st;
    clks(3);
    i_enable <= 1'h1;
    wait_st(4'h3);
    cmp(o_cfg, e);
    cmp(o_current_limit_sense_scale, e[4:3]);
    cmp(o_dac, 32'h5);
    cmp(o_pwm[0], PWM_HIGH);
  endtask : go
  // ****************
  // scenarios
  // ****************
  task automatic t_regs;
    bus(1'h0, 8'h00, 32'h0);
    cmp(q, 32'h0);
    cmp(o_hresp, 1'h0);
    bus(1'h1, 8'h00, 32'h105);
    bus(1'h0, 8'h00, 32'h0);
    cmp(q, 32'h105);
    bus(1'h1, 8'h08, 32'hffffffff);
    bus(1'h0, 8'h08, 32'h0);
    cmp(q, 32'h0);
    bus(1'h1, 8'h00, 32'h5);
  endtask : t_regs
  task automatic t_cfg;
    logic [4:0] tbl [8] = '{5'h00, 5'h04, 5'h01, 5'h05, 5'h12, 5'h14, 5'h18, 5'h08};
    foreach (tbl[i]) go(tbl[i]);
    bus(1'h1, 8'h00, 32'h205);
    clks(3);
    cmp(o_current_limit_sense_scale, 2'h2);
    bus(1'h1, 8'h00, 32'h5);
  endtask : t_cfg
  task automatic t_uv;
    cmp(o_core_regulation_good_oe, 1'h0);
    i_sense.out_uv <= 1'h1;
    clks(3);
    cmp(o_core_regulation_good_oe, 1'h1);
    i_sense.out_uv <= 1'h0;
    brown <= 1'h1;
    clks(1);
    brown <= 1'h0;
    clks(4);
    cmp(o_pwm, {4{PWM_MID}});
    wait_st(4'h3);
    i_sense.ramp_supply_uv <= 1'h1;
    clks(3);
    cmp(o_pwm[0], PWM_MID);
    i_sense.ramp_supply_uv <= 1'h0;
    wait_st(4'h3);
  endtask : t_uv
  task automatic t_ocp;
    i_sense.current_limit_sense_over_100 <= 1'h1;
    clks(OCP - 2);
    i_sense.current_limit_sense_over_100 <= 1'h0;
    clks(2);
    cmp(o_pwm[0], PWM_HIGH);
    i_sense.current_limit_sense_over_100 <= 1'h1;
    clks(OCP + 4);
    i_sense.current_limit_sense_over_100 <= 1'h0;
    clks(4);
    cmp(o_pwm, {4{PWM_MID}});
    cmp(o_driver_power_ok_oe, 1'h1);
    go(5'h00);
    i_sense.current_limit_sense_over_150 <= 1'h1;
    clks(3);
    cmp(o_pwm[0], PWM_MID);
    i_sense.current_limit_sense_over_150 <= 1'h0;
  endtask : t_ocp
  task automatic t_ovp;
    go(5'h00);
    i_dynamic_voltage_change <= 1'h1;
    i_sense.ovp_dac <= 1'h1;
    clks(4);
    cmp(o_pwm[0], PWM_HIGH);
    i_dynamic_voltage_change <= 1'h0;
    clks(3);
    cmp(o_pwm[0], PWM_LOW);
    i_sense.ovp_dac <= 1'h0;
    clks(3);
    cmp(o_pwm[0], PWM_HIGH);
    wait_st(4'h5);
    cmp(o_dac, 32'h0);
    cmp(o_pwm, 32'h0);
    cmp(o_driver_power_ok_oe, 1'h0);
    clks(20);
    wait_st(4'h5);
    go(5'h00);
    i_dynamic_voltage_change <= 1'h1;
    i_sense.ovp_current_sense_reference <= 1'h1;
    clks(3);
    cmp(o_pwm[0], PWM_LOW);
    wait_st(4'h5);
    i_sense.ovp_current_sense_reference <= 1'h0;
    i_dynamic_voltage_change <= 1'h0;
  endtask : t_ovp
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'h0;
    t_regs;
    t_cfg;
    t_uv;
    t_ocp;
    t_ovp;
    wrap_up;
  end
endmodule : vrf_supervisor_tb_top
